/* design/fms_pkg.sv */
// fms_pkg: register map, field positions and reset values of the fan
// monitor status/capability register block.
// assumes: apb byte addresses are four times the register index.
package fms_pkg;

  // ------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_SUMMARY_STATUS = 8'h00;
  localparam logic [7:0] IDX_CONFIG = 8'h01;
  localparam logic [7:0] IDX_FAN_CAPABILITY = 8'h02;
  localparam logic [7:0] IDX_FANS_IN_USE = 8'h03;
  localparam logic [7:0] IDX_GP_PIN_CAPABILITY = 8'h04;
  localparam logic [7:0] IDX_FAN_ALARM_SPEED = 8'h07;
  localparam logic [7:0] IDX_FAN_HOT_PLUG_SPEED = 8'h08;
  localparam logic [7:0] IDX_FAN_FORCE_FULL_SPEED = 8'h09;
  localparam logic [7:0] IDX_FAN1_STATUS = 8'h10;
  localparam logic [7:0] IDX_FAN2_STATUS = 8'h11;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int NUM_FANS = 2;
  localparam int NUM_GP = 7;
  localparam int NUM_AIN = 2;
  localparam int NUM_TEMP = 3;

  // ------------------------------------------------------------
  // reset and constant values
  // ------------------------------------------------------------
  localparam logic [7:0] FAN_CAPABILITY_VAL = 8'h03;
  localparam logic [7:0] GP_PIN_CAPABILITY_VAL = 8'h7f;
  localparam logic [1:0] FAN_FORCE_FULL_RST = 2'h0;
  localparam logic [1:0] FAN_ALARM_RST = 2'h0;
  localparam logic [1:0] FAN_HOT_PLUG_RST = 2'h0;
  localparam logic FAN1_IN_USE_RST = 1'b1;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ------------------------------------------------------------
  // configuration register fields
  // ------------------------------------------------------------
  localparam int CFG_INSTALL = 0;
  localparam int CFG_INT_MASK = 1;
  localparam int CFG_ALERT_DIS = 2;
  localparam int CFG_FREE_WHEEL = 3;
  localparam int CFG_START_MON = 4;
  localparam int CFG_FORCE_CASCADE = 5;
  localparam int CFG_FORCE_INT = 6;
  localparam int CFG_INT_POL = 7;

  // ------------------------------------------------------------
  // summary status fields
  // ------------------------------------------------------------
  localparam int ST_INT = 0;
  localparam int ST_CASCADE_IN = 1;
  localparam int ST_CASCADE_OUT = 2;
  localparam int ST_ALARM = 3;
  localparam int ST_HOT_PLUG = 4;
  localparam int ST_GP_EVENT = 5;
  localparam int ST_FAN_EVENT = 6;
  localparam int ST_THERMAL = 7;

  // ------------------------------------------------------------
  // per-fan status fields
  // ------------------------------------------------------------
  localparam int FS_MISSING = 0;
  localparam int FS_MISSING_L = 1;
  localparam int FS_FAULT = 2;
  localparam int FS_FAULT_L = 3;
  localparam int FS_SLEEP = 4;
  localparam int FS_HP_PRIO = 5;
  localparam int FS_TACH_L = 6;
  localparam int FS_HOT_PLUG_L = 7;
  localparam logic [7:0] FS_EVENT_MASK = 8'hca;
  localparam logic [7:0] FS_RW_MASK = 8'h30;
  localparam logic [3:0] GP_EVENT_MASK = 4'hf;

endpackage : fms_pkg

/* design/fms_fan_if.sv */
// fms_fan_if: carries per-fan status writes from the register block to
// the fan event latch and the status bytes back.
// assumes: one pclk domain on both sides.
`timescale 1ns/100ps
`default_nettype none
interface fms_fan_if;
  logic [1:0] wr_stb;
  logic [7:0] wdata;
  logic [7:0] status [2];

  modport regs (output wr_stb, output wdata, input status);
  modport fan (input wr_stb, input wdata, output status);
endinterface : fms_fan_if
`default_nettype wire

/* design/fms_fan_events.sv */
// fms_fan_events: per-fan status bytes with edge-latched event flags.
// assumes: fan pins are asynchronous; tach fault pulses are on pclk.
`timescale 1ns/100ps
`default_nettype none
module fms_fan_events (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fan pins, one bit per fan
  input wire logic [1:0] fan_present_n,
  input wire logic [1:0] fan_fault_n,
  input wire logic [1:0] tach_fault,
  // register side
  fms_fan_if.fan bus
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] pres_s1_q;
  logic [1:0] pres_s2_q;
  logic [1:0] pres_d_q;
  logic [1:0] flt_s1_q;
  logic [1:0] flt_s2_q;
  logic [1:0] flt_d_q;
  // edge detectors stay blind until the delay stage holds a real pin level,
  // else an installed fan reads as a hot-plug right after reset
  logic [2:0] arm_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres_s1_q <= 2'h3;
      pres_s2_q <= 2'h3;
      pres_d_q <= 2'h3;
      flt_s1_q <= 2'h3;
      flt_s2_q <= 2'h3;
      flt_d_q <= 2'h3;
      arm_q <= 3'h0;
    end else begin
      pres_s1_q <= fan_present_n;
      pres_s2_q <= pres_s1_q;
      pres_d_q <= pres_s2_q;
      flt_s1_q <= fan_fault_n;
      flt_s2_q <= flt_s1_q;
      flt_d_q <= flt_s2_q;
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end

  // ------------------------------------------------------------
  // latched flags per fan
  // ------------------------------------------------------------
  logic [7:0] st_q [2];

  for (genvar f = 0; f < 2; f++) begin : g_fan
    logic ev_missing;
    logic ev_fault;
    logic ev_hot_plug;
    logic clr_wr;
    logic absent;

    assign absent = pres_s2_q[f];
    assign ev_missing = pres_s2_q[f] & ~pres_d_q[f] & arm_q[2];
    assign ev_hot_plug = ~pres_s2_q[f] & pres_d_q[f] & arm_q[2];
    assign ev_fault = ~flt_s2_q[f] & flt_d_q[f] & arm_q[2];
    assign clr_wr = bus.wr_stb[f];

    // a write of 0 clears a flag, but a same-cycle event keeps it set
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q[f] <= 8'h00;
      end else begin
        st_q[f][fms_pkg::FS_MISSING] <= absent;
        st_q[f][fms_pkg::FS_FAULT] <= ~flt_s2_q[f];
        st_q[f][fms_pkg::FS_MISSING_L] <= ev_missing |
          (st_q[f][fms_pkg::FS_MISSING_L] &
           ~(clr_wr & ~bus.wdata[fms_pkg::FS_MISSING_L]));
        st_q[f][fms_pkg::FS_FAULT_L] <= (ev_fault & ~absent) |
          (st_q[f][fms_pkg::FS_FAULT_L] & ~absent &
           ~(clr_wr & ~bus.wdata[fms_pkg::FS_FAULT_L]));
        st_q[f][fms_pkg::FS_TACH_L] <= (tach_fault[f] & ~absent) |
          (st_q[f][fms_pkg::FS_TACH_L] & ~absent &
           ~(clr_wr & ~bus.wdata[fms_pkg::FS_TACH_L]));
        st_q[f][fms_pkg::FS_HOT_PLUG_L] <= ev_hot_plug |
          (st_q[f][fms_pkg::FS_HOT_PLUG_L] &
           ~(clr_wr & ~bus.wdata[fms_pkg::FS_HOT_PLUG_L]));
        if (clr_wr) begin
          st_q[f][fms_pkg::FS_SLEEP] <= bus.wdata[fms_pkg::FS_SLEEP];
          st_q[f][fms_pkg::FS_HP_PRIO] <= bus.wdata[fms_pkg::FS_HP_PRIO];
        end
      end
    end

    assign bus.status[f] = st_q[f];
  end

endmodule // fms_fan_events
`default_nettype wire

/* design/fms_regs.sv */
// fms_regs: apb register block of a dual fan monitor: summary status,
// capability, fans-in-use, speed overrides and per-fan status.
// assumes: event sources other than fan pins come from pclk-domain logic.
//
// Operation
// - two force-full-speed bits, reset zero
// - reserved bits read zero, writes ignored
// - status bit0 shows interrupt driven low
// - status bits 3,4,5,6,7 are live ORs
// - status bit1: cascade fault received from others
// - status bit2: this device drives cascade fault
// - status bit3: some fan at alarm speed
// - status bit4: some fan at hot-plug speed
// - status bit5: input pin and analog events
// - status bit6: OR of fan event flags
// - status bit7: OR of thermal fault bits
// - fan capability constant 03h, read-only
// - fan1 in-use set at reset, writable
// - fan2 in-use loaded from install strap
// - pin capability constant 7fh, read-only
// - fan event flags latch, cleared by zero
// - config install bit mirrors fan2 in-use
// - monitoring stopped forces all fans alarm speed
`timescale 1ns/100ps
`default_nettype none
module fms_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fan pins
  input wire logic [1:0] fan_present_n,
  input wire logic [1:0] fan_fault_n,
  input wire logic [1:0] tach_fault,
  // strap and cascade fault pin
  input wire logic min_temp_install_strap,
  input wire logic cascade_fault_line_in,
  output logic cascade_fault_line_out,
  output logic cascade_fault_line_oe,
  // event sources from neighbouring register blocks
  input wire logic [27:0] gp_behaviour_bits,
  input wire logic [6:0] gp_is_input,
  input wire logic [1:0] analog_input_event,
  input wire logic [2:0] temp_fault_event,
  // interrupt pin and fan speed requests
  output logic int_pin,
  output logic [1:0] fan_full_speed,
  output logic [1:0] fan_alarm_speed,
  output logic [1:0] fan_hot_plug_speed
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic fan_event(input logic [7:0] s);
    fan_event = |(s & fms_pkg::FS_EVENT_MASK);
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // ------------------------------------------------------------
  // fan event latch
  // ------------------------------------------------------------
  fms_fan_if fan_bus ();

  fms_fan_events u_fan_events (
    .pclk(pclk),
    .presetn(presetn),
    .fan_present_n(fan_present_n),
    .fan_fault_n(fan_fault_n),
    .tach_fault(tach_fault),
    .bus(fan_bus.fan)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic setup;
  logic access;
  logic wr_en;
  logic [7:0] idx;
  logic addr_ok;
  logic [7:0] wbyte;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign idx = paddr[fms_pkg::IDX_LSB +: 8];
  assign addr_ok = (paddr[fms_pkg::IDX_LSB-1:0] == 2'h0) &&
                   (paddr[fms_pkg::ADDR_W-1:fms_pkg::IDX_LSB+8] == 2'h0);
  assign wbyte = pwdata[7:0];

  logic mapped;
  always_comb begin
    unique case (idx)
      fms_pkg::IDX_SUMMARY_STATUS, fms_pkg::IDX_CONFIG,
      fms_pkg::IDX_FAN_CAPABILITY, fms_pkg::IDX_FANS_IN_USE,
      fms_pkg::IDX_GP_PIN_CAPABILITY, fms_pkg::IDX_FAN_ALARM_SPEED,
      fms_pkg::IDX_FAN_HOT_PLUG_SPEED, fms_pkg::IDX_FAN_FORCE_FULL_SPEED,
      fms_pkg::IDX_FAN1_STATUS, fms_pkg::IDX_FAN2_STATUS: mapped = addr_ok;
      default: mapped = 1'b0;
    endcase
  end

  // writes land only on the completing edge of an error-free access
  assign wr_en = access & pwrite & mapped;

  // ------------------------------------------------------------
  // writable state
  // ------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [1:0] full_q;
  logic [1:0] alarm_q;
  logic [1:0] hot_plug_q;
  logic fan1_used_q;
  logic fan2_used_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= fms_pkg::FAN_FORCE_FULL_RST;
    end else if (wr_en && idx == fms_pkg::IDX_FAN_FORCE_FULL_SPEED) begin
      full_q <= wbyte[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q <= fms_pkg::FAN_ALARM_RST;
      hot_plug_q <= fms_pkg::FAN_HOT_PLUG_RST;
    end else begin
      if (wr_en && idx == fms_pkg::IDX_FAN_ALARM_SPEED) begin
        alarm_q <= wbyte[1:0];
      end
      if (wr_en && idx == fms_pkg::IDX_FAN_HOT_PLUG_SPEED) begin
        hot_plug_q <= wbyte[1:0];
      end
    end
  end

  // install bit lives once, seen in config and fans-in-use alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= fms_pkg::CONFIG_RST;
    end else if (wr_en && idx == fms_pkg::IDX_CONFIG) begin
      cfg_q <= wbyte;
    end
  end

  // ------------------------------------------------------------
  // install strap capture after reset release
  // ------------------------------------------------------------
  logic strap_s1_q;
  logic strap_s2_q;
  logic [1:0] strap_cnt_q;
  logic strap_done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= min_temp_install_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // the strap is sampled only once the synchroniser holds a real level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      strap_done_q <= (strap_cnt_q == fms_pkg::STRAP_WAIT);
    end
  end

  logic wr_fan2_used;
  assign wr_fan2_used = wr_en &&
    (idx == fms_pkg::IDX_FANS_IN_USE || idx == fms_pkg::IDX_CONFIG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan1_used_q <= fms_pkg::FAN1_IN_USE_RST;
      fan2_used_q <= 1'b0;
    end else begin
      if (wr_en && idx == fms_pkg::IDX_FANS_IN_USE) begin
        fan1_used_q <= wbyte[0];
      end
      if (wr_fan2_used) begin
        fan2_used_q <= (idx == fms_pkg::IDX_CONFIG) ?
          wbyte[fms_pkg::CFG_INSTALL] : wbyte[1];
      end else if (!strap_done_q && strap_cnt_q == fms_pkg::STRAP_WAIT) begin
        fan2_used_q <= strap_s2_q;
      end
    end
  end

  // ------------------------------------------------------------
  // cascade fault pin
  // ------------------------------------------------------------
  logic casc_s1_q;
  logic casc_s2_q;
  logic casc_drive_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      casc_s1_q <= 1'b1;
      casc_s2_q <= 1'b1;
    end else begin
      casc_s1_q <= cascade_fault_line_in;
      casc_s2_q <= casc_s1_q;
    end
  end

  // ------------------------------------------------------------
  // live summary status, rebuilt every cycle
  // ------------------------------------------------------------
  logic [1:0] alarm_run;
  logic [1:0] hot_plug_run;
  logic [7:0] sum;
  logic int_active;
  logic [3:0] gp_flags [7];
  logic gp_any;
  logic casc_cause;

  always_comb begin
    gp_any = |analog_input_event;
    for (int g = 0; g < fms_pkg::NUM_GP; g++) begin
      gp_flags[g] = gp_behaviour_bits[4*g +: 4] & fms_pkg::GP_EVENT_MASK;
      gp_any = gp_any | (gp_is_input[g] & (|gp_flags[g]));
    end
  end

  // a stopped monitor parks every fan at alarm speed
  assign alarm_run = alarm_q | {2{~cfg_q[fms_pkg::CFG_START_MON]}};
  assign hot_plug_run = hot_plug_q;
  assign casc_cause = cfg_q[fms_pkg::CFG_FORCE_CASCADE] | (|temp_fault_event);

  always_comb begin
    sum = 8'h00;
    sum[fms_pkg::ST_CASCADE_IN] = ~casc_s2_q & ~casc_drive_q;
    sum[fms_pkg::ST_CASCADE_OUT] = casc_drive_q;
    sum[fms_pkg::ST_ALARM] = |alarm_run;
    sum[fms_pkg::ST_HOT_PLUG] = |hot_plug_run;
    sum[fms_pkg::ST_GP_EVENT] = gp_any;
    sum[fms_pkg::ST_FAN_EVENT] = fan_event(fan_bus.status[0]) |
                                 fan_event(fan_bus.status[1]);
    sum[fms_pkg::ST_THERMAL] = |temp_fault_event;
    int_active = ~cfg_q[fms_pkg::CFG_INT_MASK] &
      (cfg_q[fms_pkg::CFG_FORCE_INT] | sum[fms_pkg::ST_GP_EVENT] |
       sum[fms_pkg::ST_FAN_EVENT] | sum[fms_pkg::ST_THERMAL]);
    sum[fms_pkg::ST_INT] = int_pin == 1'b0 && int_active;
  end

  // ------------------------------------------------------------
  // pin and speed outputs
  // ------------------------------------------------------------
  logic int_pin_q;
  logic [1:0] alarm_out_q;
  logic [1:0] hot_plug_out_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pin_q <= 1'b1;
      casc_drive_q <= 1'b0;
      alarm_out_q <= 2'h0;
      hot_plug_out_q <= 2'h0;
    end else begin
      int_pin_q <= ~(int_active ^ cfg_q[fms_pkg::CFG_INT_POL]);
      casc_drive_q <= casc_cause;
      alarm_out_q <= alarm_run;
      hot_plug_out_q <= hot_plug_run;
    end
  end

  assign int_pin = int_pin_q;
  assign cascade_fault_line_out = 1'b0;
  assign cascade_fault_line_oe = casc_drive_q;
  assign fan_full_speed = full_q;
  assign fan_alarm_speed = alarm_out_q;
  assign fan_hot_plug_speed = hot_plug_out_q;

  // ------------------------------------------------------------
  // fan status writes
  // ------------------------------------------------------------
  assign fan_bus.wr_stb[0] = wr_en && idx == fms_pkg::IDX_FAN1_STATUS;
  assign fan_bus.wr_stb[1] = wr_en && idx == fms_pkg::IDX_FAN2_STATUS;
  assign fan_bus.wdata = wbyte;

  // ------------------------------------------------------------
  // read mux, no wait state; every answer is loaded into a flop in the setup cycle
  // ------------------------------------------------------------
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    unique case (idx)
      fms_pkg::IDX_SUMMARY_STATUS: rbyte = sum;
      fms_pkg::IDX_CONFIG: rbyte = {cfg_q[7:1], fan2_used_q};
      fms_pkg::IDX_FAN_CAPABILITY: rbyte = fms_pkg::FAN_CAPABILITY_VAL;
      fms_pkg::IDX_FANS_IN_USE: rbyte = {6'h00, fan2_used_q, fan1_used_q};
      fms_pkg::IDX_GP_PIN_CAPABILITY: rbyte = fms_pkg::GP_PIN_CAPABILITY_VAL;
      fms_pkg::IDX_FAN_ALARM_SPEED: rbyte = {6'h00, alarm_q};
      fms_pkg::IDX_FAN_HOT_PLUG_SPEED: rbyte = {6'h00, hot_plug_q};
      fms_pkg::IDX_FAN_FORCE_FULL_SPEED: rbyte = {6'h00, full_q};
      fms_pkg::IDX_FAN1_STATUS: rbyte = fan_bus.status[0];
      fms_pkg::IDX_FAN2_STATUS: rbyte = fan_bus.status[1];
      default: rbyte = 8'h00;
    endcase
  end

  // read-only registers have no write path at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= ~mapped;
        prdata_q <= (!pwrite && mapped) ? byte_word(rbyte) : 32'h00000000;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule // fms_regs
`default_nettype wire

/* bench/fms_regs_assertions.sv */
// fms_regs_assertions: apb and register checks on fms_regs ports.
// assumes: bound into fms_regs; one pclk domain.
`timescale 1ns/100ps
`default_nettype none
module fms_regs_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic cascade_fault_line_out,
  input wire logic cascade_fault_line_oe,
  input wire logic [2:0] temp_fault_event,
  input wire logic int_pin,
  input wire logic [1:0] fan_full_speed,
  input wire logic [1:0] fan_alarm_speed
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mon_q;
  // ------------------------------------------------------------
  // shadow of start-monitoring bit
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mon_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 12'h004) mon_q <= pwdata[4];
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_s;
    psel && penable && pready && pwrite;
  endsequence
  sequence mask_wr_s;
    wr_s ##0 (paddr == 12'h004 && pwdata[1] && !pwdata[7]);
  endsequence
  ready_once_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not one cycle");
  ready_place_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  fan_cap_a: assert property (setup_s ##0 (!pwrite && paddr == 12'h008) |=>
    prdata == 32'h3 && !pslverr) else $error("fan capability wrong");
  gp_cap_a: assert property (setup_s ##0 (!pwrite && paddr == 12'h010) |=>
    prdata == 32'h7f) else $error("pin capability wrong");
  unmapped_a: assert property (setup_s ##0 (paddr == 12'h014) |=> pslverr)
    else $error("unmapped not refused");
  full_speed_a: assert property (wr_s ##0 (paddr == 12'h024) |=>
    {30'h0, fan_full_speed} == ($past(pwdata) & 32'h3)) else $error("full speed wrong");
  alarm_stop_a: assert property (!mon_q && !$past(mon_q) && $past(presetn, 2) |->
    fan_alarm_speed == 2'h3) else $error("alarm speed missing");
  cascade_drv_a: assert property ($rose(|temp_fault_event) |-> ##[1:3] cascade_fault_line_oe)
    else $error("cascade not driven");
  open_drain_a: assert property (cascade_fault_line_oe |-> !cascade_fault_line_out)
    else $error("cascade drives high");
  int_mask_a: assert property (mask_wr_s |=> ##2 int_pin [*4])
    else $error("masked int active");
endmodule // fms_regs_assertions
`default_nettype wire

/* bench/fms_peer_model.sv */
// fms_peer_model: another device on the shared cascade fault line.
// assumes: line has a pull-up; either party may sink it.
`timescale 1ns/100ps
`default_nettype none
module fms_peer_model (
  // bench control
  input wire logic peer_pull,
  // block side
  input wire logic dut_oe,
  input wire logic dut_out,
  output logic line
);
  // ------------------------------------------------------------
  // wired-and line
  // ------------------------------------------------------------
  // released line goes to the pull-up level, never a stale low
  assign line = ((dut_oe && !dut_out) || peer_pull) ? 1'b0 : 1'b1;
endmodule // fms_peer_model
`default_nettype wire

/* bench/fms_regs_tb.sv */
// fms_regs_tb: self-checking bench of the fan monitor register block.
// assumes: 100 mhz pclk; apb master here; cascade peer model.
`timescale 1ns/100ps
`default_nettype none
module fms_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, strap, peer_pull, er;
  logic pready, pslverr, line, c_out, c_oe, int_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] fan_present_n, fan_fault_n, tach_fault, ai, ffs, hps;
  logic [27:0] gpb;
  logic [6:0] gpi;
  logic [2:0] tf;
  logic [7:0] d;
  int seed = 32'he3efd1ea;
  int bad_count = 0;
  int samples_checked = 0;
  fms_regs dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fan_present_n, .fan_fault_n, .tach_fault, .min_temp_install_strap(strap),
    .cascade_fault_line_in(line), .cascade_fault_line_out(c_out),
    .cascade_fault_line_oe(c_oe), .gp_behaviour_bits(gpb), .gp_is_input(gpi),
    .analog_input_event(ai), .temp_fault_event(tf), .int_pin,
    .fan_full_speed(ffs), .fan_alarm_speed(), .fan_hot_plug_speed(hps)
  );
  fms_peer_model peer (.peer_pull, .dut_oe(c_oe), .dut_out(c_out), .line);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk(rd[7:0] & m, e);
  endtask
  task automatic w4();
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic gp_ev(logic [27:0] b, logic [6:0] i, logic [1:0] a);
    logic r;
    r = |a;
    for (int g = 0; g < 7; g++) r = r | (i[g] & (|b[4*g +: 4]));
    return r;
  endfunction
  function automatic logic [7:0] st_exp(logic g, logic t);
    return {t, 1'b0, g, 2'b00, t, 1'b0, g | t};
  endfunction
  // ------------------------------------------------------------
  // stimulus and checks
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    fan_present_n = 2'h0;
    fan_fault_n = 2'h3;
    tach_fault = 2'h0;
    peer_pull = 1'b0;
    gpb = 28'h0;
    gpi = 7'h0;
    ai = 2'h0;
    tf = 3'h0;
    strap = 1'($random(seed));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    w4();
    rc(12'h008, 8'h03, 8'hff);
    rc(12'h010, 8'h7f, 8'hff);
    rc(12'h024, 8'h00, 8'hff);
    rc(12'h00c, {6'h0, strap, 1'b1}, 8'hff);
    rc(12'h004, {7'h0, strap}, 8'hff);
    rc(12'h000, 8'h08, 8'h08);
    rc(12'h040, 8'h00, 8'hff);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hff : 8'($random(seed));
      apb(1'b1, 12'h008, d);
      apb(1'b1, 12'h010, d);
      apb(1'b1, 12'h024, d);
      apb(1'b1, 12'h00c, d);
      rc(12'h008, 8'h03, 8'hff);
      rc(12'h010, 8'h7f, 8'hff);
      rc(12'h024, d & 8'h03, 8'hff);
      chk({6'h0, ffs}, {6'h0, d[1:0]});
      rc(12'h00c, d & 8'h03, 8'hff);
      rc(12'h004, {7'h0, d[1]}, 8'hff);
    end
    apb(1'b0, 12'h014, 8'h00);
    chk({7'h0, er}, 8'h01);
    chk(rd[7:0], 8'h00);
    apb(1'b1, 12'h004, 8'h10);
    w4();
    rc(12'h000, 8'h00, 8'h18);
    apb(1'b1, 12'h01c, 8'h02);
    w4();
    rc(12'h000, 8'h08, 8'h18);
    apb(1'b1, 12'h01c, 8'h00);
    apb(1'b1, 12'h020, 8'h01);
    w4();
    rc(12'h000, 8'h10, 8'h18);
    chk({6'h0, hps}, 8'h01);
    apb(1'b1, 12'h020, 8'h00);
    apb(1'b1, 12'h040, 8'h00);
    apb(1'b1, 12'h044, 8'h00);
    for (int k = 0; k < 16; k++) begin
      gpb <= (k % 2 == 1) ? 28'($random(seed)) : 28'h0;
      gpi <= 7'($random(seed));
      ai <= (k % 4 == 1) ? 2'($random(seed)) : 2'h0;
      tf <= (k % 3 == 0) ? 3'($random(seed)) : 3'h0;
      w4();
      rc(12'h000, st_exp(gp_ev(gpb, gpi, ai), |tf), 8'hff);
      chk({7'h0, int_pin}, {7'h0, ~(gp_ev(gpb, gpi, ai) | (|tf))});
    end
    tf <= 3'h4;
    apb(1'b1, 12'h004, 8'h12);
    w4();
    chk({7'h0, int_pin}, 8'h01);
    rc(12'h000, 8'h84, 8'h85);
    apb(1'b1, 12'h004, 8'h10);
    w4();
    rc(12'h000, 8'h85, 8'h85);
    chk({7'h0, int_pin}, 8'h00);
    tf <= 3'h0;
    peer_pull <= 1'b1;
    w4();
    rc(12'h000, 8'h02, 8'h06);
    peer_pull <= 1'b0;
    fan_present_n <= 2'b01;
    w4();
    rc(12'h040, 8'h03, 8'h03);
    rc(12'h000, 8'h40, 8'h42);
    apb(1'b1, 12'h040, 8'h00);
    rc(12'h040, 8'h01, 8'h03);
    rc(12'h000, 8'h00, 8'h40);
    tach_fault <= 2'b10;
    @(posedge pclk);
    tach_fault <= 2'b00;
    w4();
    rc(12'h044, 8'h40, 8'h40);
    apb(1'b1, 12'h004, 8'hf0);
    w4();
    chk({7'h0, int_pin}, 8'h01);
    rc(12'h000, 8'h04, 8'h05);
    results();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    results();
  end
endmodule // fms_regs_tb
bind fms_regs fms_regs_assertions chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .cascade_fault_line_out, .cascade_fault_line_oe, .temp_fault_event, .int_pin,
  .fan_full_speed, .fan_alarm_speed
);
`default_nettype wire
